// >>> verilog/qei_regs.svh
// Register offsets, field positions, reset values and timing counts of the encoder interface
`ifndef QEI_REGS_SVH
`define QEI_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define QEI_OFS_CONTROL   12'h000
`define QEI_OFS_FILTER    12'h004
`define QEI_OFS_POSITION  12'h008
`define QEI_OFS_MAXCOUNT  12'h00c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define QEI_CON_ERR       15
`define QEI_CON_SIDL      13
`define QEI_CON_INDEX     12
`define QEI_CON_DIR       11
`define QEI_CON_MODE_HI   10
`define QEI_CON_MODE_LO   8
`define QEI_CON_SWAP      7
`define QEI_CON_DIROUT    6
`define QEI_CON_GATE      5
`define QEI_CON_PS_HI     4
`define QEI_CON_PS_LO     3
`define QEI_CON_INDEX_RESET_ENABLE    2
`define QEI_CON_TCS       1
`define QEI_CON_DIRSRC    0
`define QEI_CON_WMASK     16'h27ff

// ----------------------------------------------------------------
// Filter register fields
// ----------------------------------------------------------------
`define QEI_FLT_IMV_HI    10
`define QEI_FLT_IMV_LO    9
`define QEI_FLT_COUNT_ERROR_IRQ_DISABLE      8
`define QEI_FLT_OUT       7
`define QEI_FLT_CK_HI     6
`define QEI_FLT_CK_LO     4
`define QEI_FLT_WMASK     16'h07f0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define QEI_CON_RESET     16'h0000
`define QEI_FLT_RESET     16'h0000
`define QEI_MAX_RESET     16'hffff
`define QEI_FILTER_TICKS  3

`endif

// >>> verilog/qei_pkg.sv
// Types used by the encoder interface top module, qei_top
package qei_pkg;

    typedef enum logic [2:0] {
        QEI_MODE_OFF     = 3'b000,
        QEI_MODE_TIMER   = 3'b001,
        QEI_MODE_UNUSED2 = 3'b010,
        QEI_MODE_UNUSED3 = 3'b011,
        QEI_MODE_X2_IDX  = 3'b100,
        QEI_MODE_X2_MAX  = 3'b101,
        QEI_MODE_X4_IDX  = 3'b110,
        QEI_MODE_X4_MAX  = 3'b111
    } qei_mode_t;

    typedef enum logic {
        QEI_BUS_IDLE,
        QEI_BUS_DATA
    } qei_bus_state_t;

    // Three encoder lines travelling together
    typedef struct packed {
        logic index;
        logic phase_b;
        logic phase_a;
    } qei_pins_t;

endpackage

// >>> verilog/qei_filter.sv
// Digital noise filter for one encoder line
`timescale 1ns/1ps
`include "qei_regs.svh"

module qei_filter #(
    parameter int TICKS = `QEI_FILTER_TICKS
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    input  wire logic tick,
    input  wire logic raw,
    output logic      filt
);
    logic [3:0] stable_cnt;

    // Level passes only after TICKS stable divided-clock ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_cnt <= 4'h0;
            filt       <= 1'b0;
        end else if (ce) begin
            if (raw == filt) begin
                stable_cnt <= 4'h0;
            end else if (tick) begin
                if (stable_cnt == 4'(TICKS - 1)) begin
                    filt       <= raw;
                    stable_cnt <= 4'h0;
                end else begin
                    stable_cnt <= stable_cnt + 4'h1;
                end
            end
        end
    end
endmodule

// >>> verilog/qei_sync.sv
// Three-stage synchroniser with agreement check for the encoder pins
`timescale 1ns/1ps

module qei_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // Only s2 reads s1; level moves once s2 and s3 agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

// >>> verilog/qei_top.sv
// Quadrature encoder interface with timer mode, filters and AHB-Lite registers
//
// Summary of operation
// - 16-bit position counter follows decoded direction
// - Mode 111/110: x4, max or index reset
// - Mode 101/100: x2, max or index reset
// - 001 timer; 000, 010, 011 disabled
// - Count error flag, index modes only
// - Stop-in-idle bit freezes counting while idle
// - Direction bit read-only encoder, writable timer
// - Swap bit exchanges phase A and B
// - Direction drives pin when output enabled
// - Gate enable: timer counts only while gated
// - Timer prescale 1, 8, 64, 256
// - Index reset enable acts in 100, 110
// - Timer clock: phase A rising or system
// - Timer direction from phase B or bit
// - x4 index reset needs B,A match value
// - x2 match selects phase and level
// - Count error interrupt disable bit
// - Filter enable routes inputs through filters
// - Filter clock divide 1 to 256
`timescale 1ns/1ps
`include "qei_regs.svh"

module qei_top
    import qei_pkg::*;
#(
    parameter int FILTER_TICKS = `QEI_FILTER_TICKS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        index_input,
    input  wire logic        timer_gate,
    input  wire logic        system_idle,
    output logic             direction_pin_out,
    output logic             direction_pin_oe_n,
    output logic             count_error_irq
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] encoder_control;
    logic [15:0] encoder_filter_control;
    logic [15:0] position_counter;
    logic [15:0] maximum_count_value;
    logic        count_error_flag;
    logic        direction_status;

    qei_mode_t decoder_mode_select;
    logic      stop_when_idle;
    logic      phase_swap;
    logic      direction_pin_output_enable;
    logic      timer_gate_enable;
    logic [1:0] timer_prescale_select;
    logic      index_reset_enable;
    logic      timer_clock_source;
    logic      direction_source_select;
    logic [1:0] index_match_value;
    logic      count_error_irq_disable;
    logic      filter_output_enable;
    logic [2:0] filter_clock_divide;

    assign decoder_mode_select         = qei_mode_t'(encoder_control[`QEI_CON_MODE_HI:`QEI_CON_MODE_LO]);
    assign stop_when_idle              = encoder_control[`QEI_CON_SIDL];
    assign phase_swap                  = encoder_control[`QEI_CON_SWAP];
    assign direction_pin_output_enable = encoder_control[`QEI_CON_DIROUT];
    assign timer_gate_enable           = encoder_control[`QEI_CON_GATE];
    assign timer_prescale_select       = encoder_control[`QEI_CON_PS_HI:`QEI_CON_PS_LO];
    assign index_reset_enable          = encoder_control[`QEI_CON_INDEX_RESET_ENABLE];
    assign timer_clock_source          = encoder_control[`QEI_CON_TCS];
    assign direction_source_select     = encoder_control[`QEI_CON_DIRSRC];
    assign index_match_value           = encoder_filter_control[`QEI_FLT_IMV_HI:`QEI_FLT_IMV_LO];
    assign count_error_irq_disable     = encoder_filter_control[`QEI_FLT_COUNT_ERROR_IRQ_DISABLE];
    assign filter_output_enable        = encoder_filter_control[`QEI_FLT_OUT];
    assign filter_clock_divide         = encoder_filter_control[`QEI_FLT_CK_HI:`QEI_FLT_CK_LO];

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    logic run;
    logic enc_mode;
    logic x4_mode;
    logic idx_mode;
    logic max_mode;
    logic timer_mode;

    // Idle only freezes the counting path; the bus still answers
    assign run        = clk_en && !(stop_when_idle && system_idle);
    assign enc_mode   = decoder_mode_select[2];
    assign timer_mode = (decoder_mode_select == QEI_MODE_TIMER);
    assign x4_mode    = enc_mode && decoder_mode_select[1];
    assign idx_mode   = enc_mode && !decoder_mode_select[0];
    assign max_mode   = enc_mode && decoder_mode_select[0];

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    qei_pins_t pins_raw;
    qei_pins_t pins_sync;
    qei_pins_t pins_filt;
    qei_pins_t pins_use;
    logic [7:0] fdiv_cnt;
    logic [7:0] fdiv_limit;
    logic       fdiv_tick;

    assign pins_raw = '{index: index_input, phase_b: phase_b_input, phase_a: phase_a_input};

    // Filter clock divide table
    assign fdiv_limit = (filter_clock_divide == 3'h7) ? 8'hff :
                        (filter_clock_divide == 3'h6) ? 8'h7f :
                        (filter_clock_divide == 3'h5) ? 8'h3f :
                        (filter_clock_divide == 3'h4) ? 8'h1f :
                        (filter_clock_divide == 3'h3) ? 8'h0f :
                        (filter_clock_divide == 3'h2) ? 8'h03 :
                        (filter_clock_divide == 3'h1) ? 8'h01 : 8'h00;
    assign fdiv_tick = (fdiv_cnt >= fdiv_limit);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fdiv_cnt <= 8'h00;
        end else if (clk_en) begin
            fdiv_cnt <= fdiv_tick ? 8'h00 : fdiv_cnt + 8'h01;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_line
            qei_sync u_sync (
                .hclk    (hclk),
                .hresetn (hresetn),
                .ce      (clk_en),
                .pin     (pins_raw[gi]),
                .level   (pins_sync[gi])
            );
            qei_filter #(
                .TICKS (FILTER_TICKS)
            ) u_filter (
                .hclk    (hclk),
                .hresetn (hresetn),
                .ce      (clk_en),
                .tick    (fdiv_tick),
                .raw     (pins_sync[gi]),
                .filt    (pins_filt[gi])
            );
        end
    endgenerate

    assign pins_use = filter_output_enable ? pins_filt : pins_sync;

    logic qa;
    logic qb;
    logic qa_d;
    logic qb_d;
    logic idx_d;
    assign qa = phase_swap ? pins_use.phase_b : pins_use.phase_a;
    assign qb = phase_swap ? pins_use.phase_a : pins_use.phase_b;

    // ----------------------------------------------------------------
    // Quadrature decode
    // ----------------------------------------------------------------
    logic a_edge;
    logic b_edge;
    logic dec_step;
    logic dec_up;
    logic illegal;
    logic idx_rise;
    logic idx_match;

    assign a_edge  = qa ^ qa_d;
    assign b_edge  = qb ^ qb_d;
    assign illegal = a_edge && b_edge;
    // A leading B counts up
    assign dec_up  = a_edge ? (qa != qb) : (qa == qb);
    assign dec_step = !illegal && (x4_mode ? (a_edge || b_edge) : a_edge);
    assign idx_rise = pins_use.index && !idx_d;
    assign idx_match = x4_mode ? (qb == index_match_value[1] && qa == index_match_value[0])
                     : ((index_match_value[1] ? qb : qa) == index_match_value[0]);

    // ----------------------------------------------------------------
    // Timer path
    // ----------------------------------------------------------------
    logic       t_src;
    logic       t_src_ev;
    logic       t_gate_ok;
    logic [7:0] pre_cnt;
    logic [7:0] pre_limit;
    logic       t_step;
    logic       t_up;

    assign t_src_ev  = timer_clock_source ? (qa && !qa_d) : 1'b1;
    assign t_gate_ok = !timer_gate_enable || timer_gate;
    assign t_src     = timer_mode && t_src_ev && t_gate_ok;
    assign pre_limit = (timer_prescale_select == 2'h3) ? 8'hff :
                       (timer_prescale_select == 2'h2) ? 8'h3f :
                       (timer_prescale_select == 2'h1) ? 8'h07 : 8'h00;
    assign t_step    = t_src && (pre_cnt >= pre_limit);
    assign t_up      = direction_source_select ? qb : direction_status;

    // ----------------------------------------------------------------
    // Counter step selection
    // ----------------------------------------------------------------
    logic        step;
    logic        step_up;
    logic        idx_reset;
    logic [15:0] next_position;

    assign step      = enc_mode ? dec_step : t_step;
    assign step_up   = enc_mode ? dec_up : t_up;
    assign idx_reset = idx_mode && index_reset_enable && idx_rise && idx_match;

    always_comb begin
        next_position = position_counter;
        if (idx_reset) begin
            next_position = 16'h0000;
        end else if (step) begin
            if (step_up) begin
                if (max_mode && position_counter == maximum_count_value) begin
                    next_position = 16'h0000;
                end else begin
                    next_position = position_counter + 16'h0001;
                end
            end else begin
                if (max_mode && position_counter == 16'h0000) begin
                    next_position = maximum_count_value;
                end else begin
                    next_position = position_counter - 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    qei_bus_state_t bus_state;
    logic [11:0]    addr_q;
    logic           write_q;
    logic           addr_phase;
    logic           wr_ctl;
    logic           wr_flt;
    logic           wr_pos;
    logic           wr_max;
    logic           err_clear;
    logic [15:0]    ctl_view;
    logic [15:0]    rd_word;

    assign addr_phase = hsel && hready && htrans[1];
    assign wr_ctl = (bus_state == QEI_BUS_DATA) && write_q && (addr_q == `QEI_OFS_CONTROL);
    assign wr_flt = (bus_state == QEI_BUS_DATA) && write_q && (addr_q == `QEI_OFS_FILTER);
    assign wr_pos = (bus_state == QEI_BUS_DATA) && write_q && (addr_q == `QEI_OFS_POSITION);
    assign wr_max = (bus_state == QEI_BUS_DATA) && write_q && (addr_q == `QEI_OFS_MAXCOUNT);
    assign err_clear = wr_ctl && !hwdata[`QEI_CON_ERR];

    always_comb begin
        ctl_view                  = encoder_control;
        ctl_view[`QEI_CON_ERR]    = count_error_flag;
        ctl_view[14]              = 1'b0;
        ctl_view[`QEI_CON_INDEX]  = pins_use.index;
        ctl_view[`QEI_CON_DIR]    = direction_status;
    end

    always_comb begin
        if (addr_q == `QEI_OFS_CONTROL) begin
            rd_word = ctl_view;
        end else if (addr_q == `QEI_OFS_FILTER) begin
            rd_word = encoder_filter_control;
        end else if (addr_q == `QEI_OFS_POSITION) begin
            rd_word = position_counter;
        end else if (addr_q == `QEI_OFS_MAXCOUNT) begin
            rd_word = maximum_count_value;
        end else begin
            rd_word = 16'h0000;
        end
    end

    // Registered read data costs one wait state per transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= QEI_BUS_IDLE;
            addr_q    <= 12'h000;
            write_q   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            case (bus_state)
                QEI_BUS_IDLE: begin
                    if (addr_phase) begin
                        addr_q    <= {haddr[11:2], 2'b00};
                        write_q   <= hwrite;
                        hreadyout <= 1'b0;
                        bus_state <= QEI_BUS_DATA;
                    end
                end
                QEI_BUS_DATA: begin
                    hrdata    <= write_q ? 32'h0000_0000 : {16'h0000, rd_word};
                    hreadyout <= 1'b1;
                    bus_state <= QEI_BUS_IDLE;
                end
                default: begin
                    bus_state <= QEI_BUS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control, status and counter state
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            encoder_control        <= `QEI_CON_RESET;
            encoder_filter_control <= `QEI_FLT_RESET;
            maximum_count_value    <= `QEI_MAX_RESET;
        end else if (clk_en) begin
            if (wr_ctl) begin
                encoder_control <= hwdata[15:0] & `QEI_CON_WMASK;
            end
            if (wr_flt) begin
                encoder_filter_control <= hwdata[15:0] & `QEI_FLT_WMASK;
            end
            if (wr_max) begin
                maximum_count_value <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qa_d             <= 1'b0;
            qb_d             <= 1'b0;
            idx_d            <= 1'b0;
            pre_cnt          <= 8'h00;
            position_counter <= 16'h0000;
            direction_status <= 1'b0;
            count_error_flag <= 1'b0;
        end else if (clk_en) begin
            qa_d  <= qa;
            qb_d  <= qb;
            idx_d <= pins_use.index;
            if (wr_pos) begin
                position_counter <= hwdata[15:0];
            end else if (run) begin
                position_counter <= next_position;
            end
            if (run && t_src) begin
                pre_cnt <= t_step ? 8'h00 : pre_cnt + 8'h01;
            end
            if (enc_mode && run && dec_step) begin
                direction_status <= dec_up;
            end else if (timer_mode && direction_source_select) begin
                direction_status <= qb;
            end else if (timer_mode && wr_ctl) begin
                direction_status <= hwdata[`QEI_CON_DIR];
            end
            // Set beats a software clear in the same cycle
            if (run && idx_mode && illegal) begin
                count_error_flag <= 1'b1;
            end else if (err_clear) begin
                count_error_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            direction_pin_out  <= 1'b0;
            direction_pin_oe_n <= 1'b1;
            count_error_irq    <= 1'b0;
        end else if (clk_en) begin
            direction_pin_out  <= direction_status;
            direction_pin_oe_n <= !direction_pin_output_enable;
            count_error_irq    <= count_error_flag && !count_error_irq_disable && idx_mode;
        end
    end
endmodule

// >>> dv/qei_assertions.sv
// Bus and pin assertions for the encoder interface
`timescale 1ns/1ps
module qei_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        system_idle,
    input wire logic        direction_pin_out,
    input wire logic        direction_pin_oe_n,
    input wire logic        count_error_irq
);
    // ------
    // Control copy taken from bus writes
    // ------
    logic [15:0] con;
    logic        pend;
    wire         take = hsel && hready && htrans[1] && hreadyout;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            con  <= 16'h0000;
            pend <= 1'b0;
        end else begin
            pend <= take ? (hwrite && haddr == 12'h000) : (pend && hreadyout);
            if (pend && !hreadyout) con <= hwdata[15:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_bus_wait: assert property (take |=> s_wait) else $error("wait state not one cycle");
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper read half set");
    // Three quiet cycles let the registered pin copies settle after a write
    a_oe_follow:
        assert property ($stable(con[6])[*3] |-> direction_pin_oe_n == !con[6]) else $error("oe wrong");
    a_irq_index:
        assert property ((con[10:8] != 3'b110 && con[10:8] != 3'b100)[*3] |-> !count_error_irq)
            else $error("irq outside index mode");
    a_off_frozen:
        assert property ((con[10:8] inside {3'b000, 3'b010, 3'b011})[*3] |-> $stable(direction_pin_out))
            else $error("direction moved while off");
    a_idle_freeze:
        assert property ((con[13] && con[10] && system_idle)[*3] |-> $stable(direction_pin_out))
            else $error("direction moved while idle");
    a_timer_dir:
        assert property ((con[10:8] == 3'b001 && !con[0])[*3] |-> direction_pin_out == con[11])
            else $error("timer direction wrong");
endmodule
bind qei_top qei_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .system_idle, .direction_pin_out, .direction_pin_oe_n, .count_error_irq);

// >>> dv/qei_enc_model.sv
// Incremental encoder with index output, moved one step at a time or jumped two
`timescale 1ns/1ps
module qei_enc_model (
    input  wire logic clk,
    input  wire logic step,
    input  wire logic up,
    input  wire logic jump,
    input  wire logic idx,
    output logic      qa,
    output logic      qb,
    output logic      qi
);
    // Gray position; a jump moves two places so both lines flip together
    logic [1:0] ph = 2'h0;
    always @(posedge clk) begin
        if (jump) ph <= ph + 2'h2;
        else if (step) ph <= up ? ph + 2'h1 : ph - 2'h1;
    end
    assign qa = ph[0] ^ ph[1];
    assign qb = ph[1];
    assign qi = idx;
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the encoder interface
`timescale 1ns/1ps
module tb_top;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, step = 1'b0, up = 1'b0;
    logic        jump = 1'b0, idx = 1'b0, timer_gate = 1'b0, system_idle = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, q, q1, hrdata;
    logic        hreadyout, hresp, phase_a_input, phase_b_input, index_input;
    logic        direction_pin_out, direction_pin_oe_n, count_error_irq;
    int          bad_count = 0, num_checks = 0, cyc = 0;
    always #10 hclk = ~hclk;
    qei_top #(.FILTER_TICKS(3)) dut_u (.hclk, .hresetn, .clk_en(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .phase_a_input,
        .phase_b_input, .index_input, .timer_gate, .system_idle, .direction_pin_out, .direction_pin_oe_n,
        .count_error_irq);
    qei_enc_model enc_u (.clk(hclk), .step, .up, .jump, .idx, .qa(phase_a_input), .qb(phase_b_input),
        .qi(index_input));
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask
    // Eight idle cycles per step cover the pin synchroniser and counter update
    task automatic mv(input int n, input logic u);
        up <= u;
        repeat (n) begin
            @(posedge hclk) step <= 1'b1;
            @(posedge hclk) step <= 1'b0;
            repeat (8) @(posedge hclk);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_count;
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h00c, 32'hffff);
        bus(1'b1, 12'h010, 32'hffff);
        rd(12'h010, 32'h0);
        bus(1'b1, 12'h00c, 32'h10);
        bus(1'b1, 12'h000, 32'h0700);
        mv(2, 1'b1);
        rd(12'h008, 32'h2);
        check({31'h0, direction_pin_out}, 32'h1);
        mv(3, 1'b0);
        rd(12'h008, 32'h10);
        bus(1'b1, 12'h000, 32'h0f40);
        rd(12'h000, 32'h0740);
        check({31'h0, direction_pin_oe_n}, 32'h0);
        bus(1'b1, 12'h008, 32'h0);
        bus(1'b1, 12'h000, 32'h0500);
        mv(4, 1'b1);
        rd(12'h008, 32'h2);
        bus(1'b1, 12'h000, 32'h0780);
        bus(1'b1, 12'h008, 32'h5);
        mv(2, 1'b1);
        rd(12'h008, 32'h3);
        $display("test count done");
    endtask
    task automatic t_index;
        // Drop the swap while switched off, so the swap glitch cannot raise the error flag
        bus(1'b1, 12'h000, 32'h0004);
        bus(1'b1, 12'h000, 32'h0604);
        bus(1'b1, 12'h004, 32'h0200);
        bus(1'b1, 12'h008, 32'h7);
        idx <= 1'b1;
        repeat (8) @(posedge hclk);
        rd(12'h000, 32'h1604);
        idx <= 1'b0;
        rd(12'h008, 32'h0);
        bus(1'b1, 12'h004, 32'h0400);
        bus(1'b1, 12'h008, 32'h7);
        idx <= 1'b1;
        repeat (8) @(posedge hclk);
        idx <= 1'b0;
        rd(12'h008, 32'h7);
        check({31'h0, count_error_irq}, 32'h0);
        jump <= 1'b1;
        @(posedge hclk) jump <= 1'b0;
        repeat (10) @(posedge hclk);
        check({31'h0, count_error_irq}, 32'h1);
        bus(1'b1, 12'h004, 32'h0100);
        repeat (4) @(posedge hclk);
        check({31'h0, count_error_irq}, 32'h0);
        $display("test index done");
    endtask
    task automatic t_idle_timer;
        bus(1'b1, 12'h000, 32'h2700);
        bus(1'b1, 12'h008, 32'h0);
        system_idle <= 1'b1;
        mv(2, 1'b0);
        mv(2, 1'b1);
        rd(12'h008, 32'h0);
        system_idle <= 1'b0;
        mv(1, 1'b1);
        rd(12'h008, 32'h1);
        bus(1'b1, 12'h004, 32'h0080);
        mv(1, 1'b1);
        rd(12'h008, 32'h2);
        bus(1'b1, 12'h000, 32'h0900);
        bus(1'b1, 12'h000, 32'h0928);
        bus(1'b0, 12'h008, 32'h0);
        q1 = q;
        repeat (40) @(posedge hclk);
        rd(12'h008, q1);
        timer_gate <= 1'b1;
        bus(1'b0, 12'h008, 32'h0);
        q1 = q;
        repeat (80) @(posedge hclk);
        bus(1'b0, 12'h008, 32'h0);
        // Capture points lie 84 cycles apart, so a 1:8 prescale yields ten or eleven counts
        check({31'h0, (q - q1) inside {32'ha, 32'hb}}, 32'h1);
        $display("test idle and timer done");
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_count();
        t_index();
        t_idle_timer();
        report_and_stop();
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
endmodule
